// ---- core/alp_pkg.sv ----
// Constants, register map and state encoding of the active-mode local port.
// Assumes a single 125 MHz clock domain and an AHB-Lite register slave.
package alp_pkg;
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] ALP_CTRL_OFS = 8'h00;
  localparam logic [7:0] ALP_ADDR_OFS = 8'h04;
  localparam logic [7:0] ALP_CMD_OFS = 8'h08;
  localparam logic [7:0] ALP_STAT_OFS = 8'h0C;
  localparam logic [7:0] ALP_DATA_OFS = 8'h10;
  localparam logic [7:0] ALP_DATA_STEP = 8'h04;
  localparam int ALP_NWORDS = 4;
  // ****************************************
  // Region control field layout, one byte per region
  // ****************************************
  localparam int ALP_FIELD_W = 8;
  localparam int ALP_WS_LSB = 0;
  localparam int ALP_WID_LSB = 3;
  localparam int ALP_END_BIT = 6;
  localparam int ALP_ASE_BIT = 7;
  localparam logic [31:0] ALP_CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] ALP_WID_32 = 2'h0;
  localparam logic [1:0] ALP_WID_16 = 2'h1;
  // ****************************************
  // Command and status fields
  // ****************************************
  localparam int ALP_CMD_RGN_LSB = 0;
  localparam int ALP_CMD_WR_BIT = 2;
  localparam int ALP_CMD_LEN_LSB = 4;
  localparam int ALP_CMD_LANE_LSB = 8;
  localparam int ALP_CMD_GO_BIT = 31;
  localparam int ALP_ST_DONE_BIT = 0;
  localparam int ALP_ST_BUSY_BIT = 16;
  localparam int ALP_ST_MODE_BIT = 17;
  // ****************************************
  // Lane patterns
  // ****************************************
  localparam logic [3:0] ALP_LANES_NONE = 4'hF;
  localparam logic [3:0] ALP_LO_HALF_N = 4'hC;
  localparam logic [3:0] ALP_HI_HALF_N = 4'h3;
  localparam logic [2:0] ALP_AHB_WORD = 3'h2;
  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [5:0] {
    ALP_IDLE = 6'h01,
    ALP_ATTN = 6'h02,
    ALP_ADDR = 6'h04,
    ALP_WAIT = 6'h08,
    ALP_XFER = 6'h10,
    ALP_DONE = 6'h20
  } alp_state_t;
endpackage

// ---- core/alp_lane_steer.sv ----
// Byte lane steering between a 32-bit word and a 32, 16 or 8-bit add-on bus.
// Purely combinational; the caller registers what it drives.
`timescale 1ns/1ps
module alp_lane_steer
  import alp_pkg::*;
(
  input wire logic [31:0] dword, // Word being driven
  input wire logic [3:0] lanes_n, // Valid lanes of the word, low active
  input wire logic [1:0] wid, // Add-on bus width code
  input wire logic big, // Big endian steering
  input wire logic [1:0] dbeat, // Beat being driven
  input wire logic [31:0] mword, // Word being filled on reads
  input wire logic [1:0] mbeat, // Beat being captured
  input wire logic [31:0] bus_in, // Add-on bus input
  output logic [31:0] bus_d, // Value for the add-on bus
  output logic [3:0] beat_lanes_n, // Lanes valid in this beat
  output logic [31:0] merged // Word with captured beat merged in
);
  always_comb begin
    bus_d = dword;
    beat_lanes_n = lanes_n;
    merged = bus_in;
    if (wid == ALP_WID_16) begin
      bus_d = 32'h0000_0000;
      if (big) begin
        bus_d[15:8] = dword[dbeat[0]*16 +: 8];
        bus_d[7:0] = dword[dbeat[0]*16+8 +: 8];
      end else begin
        bus_d[15:0] = dword[dbeat[0]*16 +: 16];
      end
      beat_lanes_n = lanes_n | (dbeat[0] ? ALP_HI_HALF_N : ALP_LO_HALF_N);
      merged = mword;
      merged[mbeat[0]*16 +: 16] = big ? {bus_in[7:0], bus_in[15:8]} : bus_in[15:0];
    end else if (wid != ALP_WID_32) begin
      bus_d = {24'h00_0000, dword[dbeat*8 +: 8]};
      beat_lanes_n = lanes_n | ~(4'h1 << dbeat);
      merged = mword;
      merged[mbeat*8 +: 8] = bus_in[7:0];
    end
  end
endmodule // alp_lane_steer

// ---- core/alp_wait_count.sv ----
// Programmed wait-state counter; add-on waits pause it.
// Assumes the sequencer raises arm on the edge that opens a data phase.
`timescale 1ns/1ps
module alp_wait_count
  import alp_pkg::*;
(
  input wire logic hclk, // Clock
  input wire logic hresetn, // Asynchronous reset, low active
  input wire logic arm, // Data phase opens at this edge
  input wire logic turn, // Read after an address cycle
  input wire logic active, // Sequencer sits in a wait cycle
  input wire logic wait_n, // Add-on wait, low active
  input wire logic [2:0] waits, // Programmed wait states
  output logic fire // Next cycle is a strobe cycle
);
  logic [2:0] cnt;
  logic [2:0] base;

  always_comb begin
    base = cnt;
    if (arm) begin
      base = (turn && waits == 3'h0) ? 3'h1 : waits;
    end
  end

  assign fire = wait_n && base == 3'h0 && (arm || active);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 3'h0;
    end else if (arm || active) begin
      // A cycle caused by the add-on wait is not counted.
      cnt <= (wait_n && base != 3'h0) ? base - 3'h1 : base;
    end
  end

  hold_cnt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (active && !wait_n) |=> cnt == $past(cnt)) else $error("wait count moved in add-on wait");
  wait_cnt_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (arm && !turn && waits == 3'h3 && wait_n) ##1 (active && wait_n && !fire) [*2]
    ##1 (active && wait_n) |-> fire) else $error("three wait states not honoured");
endmodule // alp_wait_count

// ---- core/alp_port.sv ----
// Active-mode local port: AHB-Lite registers and the add-on transfer sequencer.
// Assumes all add-on pins are synchronous to hclk and the bus wire is resolved outside.
`timescale 1ns/1ps
module alp_port
  import alp_pkg::*;
(
  input wire logic hclk, // Clock, 125 MHz
  input wire logic hresetn, // Asynchronous reset, low active
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic [31:0] hrdata, // Read data
  output logic hresp, // Response, always OKAY
  input wire logic mode_strap, // Low selects active mode
  input wire logic local_wait_n, // Add-on wait request
  input wire logic [31:0] local_data_bus_in, // Data bus input
  output logic [31:0] local_data_bus_out, // Data bus output
  output logic local_data_bus_oe, // Data bus drive enable
  output logic transfer_attention_n, // Transfer pending
  output logic burst_pending_n, // More than one word pending
  output logic [1:0] region_number, // Region of the transfer
  output logic write_direction, // High for a write to the add-on
  output logic [3:0] lane_valid_n, // Valid byte lanes
  output logic address_strobe_out_n, // Address cycle strobe
  output logic data_xfer_strobe_n // Data transfer strobe
);
  // ****************************************
  // Declarations
  // ****************************************
  alp_state_t st;
  alp_state_t nst;
  logic [31:0] ctrl;
  logic [31:0] xaddr;
  logic [31:0] tx_addr;
  logic [1:0] tx_len;
  logic [3:0] tx_lanes;
  logic [31:0] mem [ALP_NWORDS];
  logic done;
  logic go_q;
  logic active_mode;
  logic strap_done;
  logic dph_wr;
  logic dph_rd;
  logic [7:0] dph_ofs;
  logic take;
  logic go;
  logic [31:0] rd_val;
  logic [1:0] beat;
  logic [1:0] word;
  logic [1:0] nb;
  logic [1:0] nwd;
  logic [1:0] bmax;
  logic last_next;
  logic last;
  logic [7:0] fld;
  logic [2:0] ws;
  logic [1:0] wid;
  logic big;
  logic asen;
  logic arm;
  logic turn;
  logic active;
  logic fire;
  logic [31:0] bus_d;
  logic [3:0] beat_lanes_n;
  logic [31:0] merged;

  assign fld = ctrl[region_number*ALP_FIELD_W +: ALP_FIELD_W];
  assign ws = fld[ALP_WS_LSB +: 3];
  assign wid = fld[ALP_WID_LSB +: 2];
  assign big = fld[ALP_END_BIT];
  assign asen = fld[ALP_ASE_BIT];
  assign bmax = (wid == ALP_WID_32) ? 2'h0 : ((wid == ALP_WID_16) ? 2'h1 : 2'h3);

  // ****************************************
  // Register slave
  // ****************************************
  assign take = hsel && htrans[1] && hready && hsize == ALP_AHB_WORD;
  assign go = dph_wr && dph_ofs == ALP_CMD_OFS && hwdata[ALP_CMD_GO_BIT]
    && st == ALP_IDLE && !go_q && active_mode;

  // Reads take one wait cycle so that a write just before is already visible.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_wr <= 1'b0;
      dph_rd <= 1'b0;
      dph_ofs <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
    end else begin
      dph_wr <= take && hwrite;
      dph_rd <= take && !hwrite;
      if (take) begin
        dph_ofs <= haddr[7:0];
      end
      hreadyout <= !(take && !hwrite);
      if (dph_rd) begin
        hrdata <= rd_val;
      end
      hresp <= 1'b0;
    end
  end

  always_comb begin
    rd_val = 32'h0000_0000;
    case (dph_ofs)
      ALP_CTRL_OFS: rd_val = ctrl;
      ALP_ADDR_OFS: rd_val = xaddr;
      ALP_CMD_OFS: begin
        rd_val[ALP_CMD_RGN_LSB +: 2] = region_number;
        rd_val[ALP_CMD_WR_BIT] = write_direction;
        rd_val[ALP_CMD_LEN_LSB +: 2] = tx_len;
        rd_val[ALP_CMD_LANE_LSB +: 4] = tx_lanes;
      end
      ALP_STAT_OFS: begin
        rd_val[ALP_ST_DONE_BIT] = done;
        rd_val[ALP_ST_BUSY_BIT] = st != ALP_IDLE || go_q;
        rd_val[ALP_ST_MODE_BIT] = active_mode;
      end
      default: begin
        for (int i = 0; i < ALP_NWORDS; i++) begin
          if (dph_ofs == ALP_DATA_OFS + 8'(i * 4)) begin
            rd_val = mem[i];
          end
        end
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= ALP_CTRL_RST;
      xaddr <= 32'h0000_0000;
    end else if (dph_wr && dph_ofs == ALP_CTRL_OFS) begin
      ctrl <= hwdata;
    end else if (dph_wr && dph_ofs == ALP_ADDR_OFS) begin
      xaddr <= hwdata;
    end
  end

  // The done flag is set by hardware; a clear in the same cycle loses.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done <= 1'b0;
    end else if (st == ALP_DONE) begin
      done <= 1'b1;
    end else if (dph_wr && dph_ofs == ALP_STAT_OFS && hwdata[ALP_ST_DONE_BIT]) begin
      done <= 1'b0;
    end
  end

  // The strap is caught on the first edge after reset is released.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_done <= 1'b0;
      active_mode <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      active_mode <= !mode_strap;
    end
  end

  // ****************************************
  // Transfer command latch
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      go_q <= 1'b0;
      tx_addr <= 32'h0000_0000;
      tx_len <= 2'h0;
      tx_lanes <= ALP_LANES_NONE;
      region_number <= 2'h0;
      write_direction <= 1'b0;
    end else begin
      go_q <= go;
      if (go) begin
        tx_addr <= xaddr;
        tx_len <= hwdata[ALP_CMD_LEN_LSB +: 2];
        tx_lanes <= hwdata[ALP_CMD_LANE_LSB +: 4];
        region_number <= hwdata[ALP_CMD_RGN_LSB +: 2];
        write_direction <= hwdata[ALP_CMD_WR_BIT];
      end
    end
  end

  // Word buffer; read beats are merged in at the strobe edge.
  for (genvar i = 0; i < ALP_NWORDS; i++) begin : g_mem
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        mem[i] <= 32'h0000_0000;
      end else if (st == ALP_XFER && !write_direction && word == 2'(i)) begin
        mem[i] <= merged;
      end else if (dph_wr && dph_ofs == ALP_DATA_OFS + 8'(i * 4)) begin
        mem[i] <= hwdata;
      end
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    nb = beat;
    nwd = word;
    if (st == ALP_IDLE) begin
      nb = 2'h0;
      nwd = 2'h0;
    end else if (st == ALP_XFER) begin
      if (beat == bmax) begin
        nb = 2'h0;
        nwd = word + 2'h1;
      end else begin
        nb = beat + 2'h1;
      end
    end
  end

  assign last = beat == bmax && word == tx_len;
  assign last_next = nb == bmax && nwd == tx_len;

  always_comb begin
    nst = st;
    arm = 1'b0;
    turn = 1'b0;
    active = 1'b0;
    case (st)
      ALP_IDLE: begin
        if (go_q) begin
          nst = ALP_ATTN;
        end
      end
      ALP_ATTN: begin
        if (local_wait_n) begin
          if (asen) begin
            nst = ALP_ADDR;
          end else begin
            arm = 1'b1;
            nst = fire ? ALP_XFER : ALP_WAIT;
          end
        end
      end
      ALP_ADDR: begin
        arm = 1'b1;
        turn = !write_direction;
        nst = fire ? ALP_XFER : ALP_WAIT;
      end
      ALP_WAIT: begin
        active = 1'b1;
        nst = fire ? ALP_XFER : ALP_WAIT;
      end
      ALP_XFER: begin
        if (last) begin
          nst = ALP_DONE;
        end else begin
          arm = 1'b1;
          nst = fire ? ALP_XFER : ALP_WAIT;
        end
      end
      ALP_DONE: nst = ALP_IDLE;
      default: nst = ALP_IDLE;
    endcase
  end

  alp_wait_count u_wait (
    .hclk(hclk),
    .hresetn(hresetn),
    .arm(arm),
    .turn(turn),
    .active(active),
    .wait_n(local_wait_n),
    .waits(ws),
    .fire(fire)
  );

  alp_lane_steer u_steer (
    .dword(mem[nwd]),
    .lanes_n(tx_lanes),
    .wid(wid),
    .big(big),
    .dbeat(nb),
    .mword(mem[word]),
    .mbeat(beat),
    .bus_in(local_data_bus_in),
    .bus_d(bus_d),
    .beat_lanes_n(beat_lanes_n),
    .merged(merged)
  );

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= ALP_IDLE;
      beat <= 2'h0;
      word <= 2'h0;
    end else begin
      st <= nst;
      beat <= nb;
      word <= nwd;
    end
  end

  // ****************************************
  // Pin outputs, all registered from the next state
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      transfer_attention_n <= 1'b1;
      data_xfer_strobe_n <= 1'b1;
      address_strobe_out_n <= 1'b1;
      local_data_bus_oe <= 1'b0;
      local_data_bus_out <= 32'h0000_0000;
      lane_valid_n <= ALP_LANES_NONE;
    end else begin
      transfer_attention_n <= nst == ALP_IDLE || nst == ALP_DONE
        || (nst == ALP_XFER && last_next);
      data_xfer_strobe_n <= nst != ALP_XFER;
      address_strobe_out_n <= nst != ALP_ADDR;
      // A wait sampled low never leads to a driving cycle, so the bus is released.
      local_data_bus_oe <= nst == ALP_ADDR || (nst == ALP_XFER && write_direction);
      local_data_bus_out <= (nst == ALP_ADDR) ? tx_addr : bus_d;
      lane_valid_n <= (nst == ALP_IDLE || nst == ALP_DONE) ? ALP_LANES_NONE
        : beat_lanes_n;
    end
  end

  // Writes release the burst flag one word earlier than reads.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      burst_pending_n <= 1'b1;
    end else if (st == ALP_IDLE) begin
      burst_pending_n <= !(nst == ALP_ATTN && tx_len != 2'h0);
    end else if (nst == ALP_DONE
      || (nst == ALP_XFER && (tx_len - nwd) <= {1'b0, write_direction})) begin
      burst_pending_n <= 1'b1;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  addr_pulse_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !address_strobe_out_n |-> asen ##1 address_strobe_out_n)
    else $error("address strobe not a single enabled cycle");
  addr_data_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !address_strobe_out_n |-> local_data_bus_oe && local_data_bus_out == tx_addr)
    else $error("address not driven during address strobe");
  wait_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st == ALP_ATTN && !local_wait_n) |=> st == ALP_ATTN && address_strobe_out_n)
    else $error("transfer started while wait was low");
  tri_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !local_wait_n |=> !local_data_bus_oe && data_xfer_strobe_n && address_strobe_out_n)
    else $error("bus driven after wait sampled low");
  direct_strobe_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st == ALP_ATTN && local_wait_n && !asen && ws == 3'h0) |=> !data_xfer_strobe_n)
    else $error("strobe not one cycle after valid attention");
  turn_cycle_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st == ALP_ADDR && !write_direction && ws == 3'h0 && local_wait_n)
    |=> data_xfer_strobe_n && !local_data_bus_oe ##1 !data_xfer_strobe_n)
    else $error("read turnaround missing");
  last_lane_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st == ALP_XFER && last) |-> transfer_attention_n ##1 lane_valid_n == ALP_LANES_NONE)
    else $error("end of transfer signalling wrong");
  burst_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (st == ALP_IDLE && go_q) |=> !transfer_attention_n && burst_pending_n == (tx_len == 2'h0))
    else $error("burst flag wrong at start");
  strap_a: assert property (@(posedge hclk) disable iff (!hresetn)
    st != ALP_IDLE |-> active_mode) else $error("transfer while not in active mode");
endmodule // alp_port

// ---- sim/alp_addon_model.sv ----
// Add-on peripheral model: answers read beats, logs write beats and addresses.
// Assumes it shares hclk with the port; the bench drives stall and clr.
`timescale 1ns/1ps
module alp_addon_model (
  input wire logic hclk, // Clock
  input wire logic hresetn, // Reset, low active
  input wire logic stall, // Bench asks for waits
  input wire logic clr, // Clears the counts
  input wire logic write_direction, // High on writes
  input wire logic address_strobe_out_n, // Address cycle
  input wire logic data_xfer_strobe_n, // Data strobe
  input wire logic local_data_bus_oe, // Port drives the bus
  input wire logic [31:0] local_data_bus_out, // Port bus value
  input wire logic [3:0] lane_valid_n, // Valid lanes, low active
  input wire logic burst_pending_n, // Burst flag, low active
  output logic local_wait_n, // Wait request
  output logic [31:0] bus // Resolved bus
);
  logic [31:0] log [16];
  logic [31:0] addr_seen;
  logic [31:0] last;
  logic [15:0] llog;
  logic [7:0] blog;
  int nbeat;
  int acnt;
  int gap;
  int run;
  assign local_wait_n = !stall;
  // A released bus shows a changing value, so stale data can never pass.
  always_comb begin
    if (local_data_bus_oe) begin
      bus = local_data_bus_out;
    end else if (!data_xfer_strobe_n && !write_direction) begin
      bus = 32'h0403_0201 + 32'(nbeat) * 32'h1010_1010;
    end else begin
      bus = ~last;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      last <= 32'h0;
      addr_seen <= 32'h0;
      nbeat <= 0;
      acnt <= 0;
      gap <= 0;
      run <= 0;
      llog <= 16'h0000;
      blog <= 8'h00;
    end else begin
      last <= bus;
      run <= run + 1;
      if (!address_strobe_out_n) begin
        addr_seen <= bus;
        acnt <= acnt + 1;
      end
      if (!data_xfer_strobe_n) begin
        log[nbeat[3:0]] <= bus;
        llog <= {llog[11:0], lane_valid_n};
        blog <= {blog[6:0], burst_pending_n};
        nbeat <= nbeat + 1;
        gap <= run + 1;
        run <= 0;
      end
      if (clr) begin
        nbeat <= 0;
        acnt <= 0;
        llog <= 16'h0000;
        blog <= 8'h00;
      end
    end
  end
endmodule // alp_addon_model

// ---- sim/tb_active_mode_local_bus_port.sv ----
// Bench for the active-mode local port: AHB register calls start transfers.
// Assumes the add-on model resolves the shared data bus.
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
  $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb_active_mode_local_bus_port
  import alp_pkg::*;
();
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic stall = 1'b0;
  logic clr = 1'b0;
  logic chop = 1'b0;
  logic strap = 1'b0;
  logic hreadyout, hresp, wait_n, oe, attn, burst, wdir, astb, dstb;
  logic [31:0] hrdata, bus, bus_out, rd;
  logic [1:0] region;
  logic [3:0] lanes;
  logic [7:0] rc [5] = '{8'h80, 8'h82, 8'h48, 8'h50, 8'h08};
  logic [31:0] rx [5] = '{32'h0403_0201, 32'h0403_0201, 32'h1112_0102, 32'h3121_1101,
    32'h1211_0201};
  int mismatches = 0;
  int samples_checked = 0;
  always #4 hclk = ~hclk;
  always @(posedge hclk) if (chop) stall <= ~stall;
  alp_port dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(ALP_AHB_WORD), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .mode_strap(strap),
    .local_wait_n(wait_n), .local_data_bus_in(bus), .local_data_bus_out(bus_out),
    .local_data_bus_oe(oe), .transfer_attention_n(attn), .burst_pending_n(burst),
    .region_number(region), .write_direction(wdir), .lane_valid_n(lanes),
    .address_strobe_out_n(astb), .data_xfer_strobe_n(dstb));
  alp_addon_model m (.hclk(hclk), .hresetn(hresetn), .stall(stall), .clr(clr),
    .write_direction(wdir), .address_strobe_out_n(astb), .data_xfer_strobe_n(dstb),
    .local_data_bus_oe(oe), .local_data_bus_out(bus_out), .lane_valid_n(lanes),
    .burst_pending_n(burst), .local_wait_n(wait_n), .bus(bus));
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic go(input logic [7:0] ctl, input logic [1:0] rg, input logic w, input int nw);
    clr <= 1'b1;
    ahb(1'b1, ALP_CTRL_OFS, {4{ctl}});
    clr <= 1'b0;
    ahb(1'b1, ALP_CMD_OFS, {1'b1, 19'h0, 4'h0, 2'h0, 2'(nw - 1), 1'b0, w, rg});
  endtask
  task automatic fin();
    int k;
    k = 0;
    rd = 32'h0;
    while (rd[ALP_ST_DONE_BIT] !== 1'b1 && k < 60) begin
      ahb(1'b0, ALP_STAT_OFS, 32'h0);
      k++;
    end
    `CHK("done", 1'b1, rd[ALP_ST_DONE_BIT])
    ahb(1'b1, ALP_STAT_OFS, 32'h1);
  endtask
  task automatic xf(input logic [7:0] ctl, input logic [1:0] rg, input logic w, input int nw);
    go(ctl, rg, w, nw);
    fin();
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Bounded well above the several hundred cycles the sequence needs.
  initial begin
    repeat (20000) @(posedge hclk);
    mismatches++;
    print_verdict();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK("idle strobes", 5'h1E, {attn, burst, astb, dstb, oe})
    `CHK("idle lanes", ALP_LANES_NONE, lanes)
    ahb(1'b0, ALP_STAT_OFS, 32'h0);
    `CHK("active mode", 1'b1, rd[ALP_ST_MODE_BIT])
    ahb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    for (int i = 0; i < ALP_NWORDS; i++) begin
      ahb(1'b1, ALP_DATA_OFS + ALP_DATA_STEP * 8'(i), 32'hDDCC_BBAA ^ 32'(i));
    end
    ahb(1'b1, ALP_ADDR_OFS, 32'hCAFE_0010);
    xf(8'h80, 2'h2, 1'b1, 1);
    `CHK("address", 32'hCAFE_0010, m.addr_seen)
    `CHK("address strobes", 1, m.acnt)
    `CHK("word", 32'hDDCC_BBAA, m.log[0])
    `CHK("region dir", 3'h5, {region, wdir})
    `CHK("end lanes", ALP_LANES_NONE, lanes)
    xf(8'h48, 2'h0, 1'b1, 1);
    `CHK("half beats", 32'hAABB_CCDD, {m.log[0][15:0], m.log[1][15:0]})
    `CHK("half lanes", 16'h00C3, m.llog)
    `CHK("no address strobe", 0, m.acnt)
    xf(8'h50, 2'h0, 1'b1, 1);
    `CHK("byte beats", 32'hAABB_CCDD, {m.log[0][7:0], m.log[1][7:0], m.log[2][7:0],
      m.log[3][7:0]})
    `CHK("byte lanes", 16'hEDB7, m.llog)
    for (int n = 0; n < 8; n++) begin
      xf(8'(n), 2'h1, 1'b1, 2);
      `CHK("strobe spacing", n + 1, m.gap)
    end
    chop <= 1'b1;
    xf(8'h00, 2'h3, 1'b1, 4);
    `CHK("spacing under waits", 2, m.gap)
    `CHK("last burst word", 32'hDDCC_BBA9, m.log[3])
    `CHK("burst flag", 8'h03, m.blog)
    // Each programmed wait follows an add-on wait while the wait pin toggles.
    xf(8'h02, 2'h3, 1'b1, 2);
    `CHK("paused count", 6, m.gap)
    chop <= 1'b0;
    @(posedge hclk);
    stall <= 1'b1;
    go(8'h80, 2'h0, 1'b1, 1);
    repeat (6) @(posedge hclk);
    `CHK("held start", 3'h3, {attn, astb, dstb})
    `CHK("held beats", 0, m.nbeat + m.acnt)
    stall <= 1'b0;
    fin();
    `CHK("released beats", 2, m.nbeat + m.acnt)
    for (int i = 0; i < 5; i++) begin
      xf(rc[i], 2'h1, 1'b0, 1);
      ahb(1'b0, ALP_DATA_OFS, 32'h0);
      `CHK("read word", rx[i], rd)
    end
    // A second reset with the strap high must leave the port refusing transfers.
    hresetn <= 1'b0;
    strap <= 1'b1;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (2) @(posedge hclk);
    `CHK("reset idle", 5'h1E, {attn, burst, astb, dstb, oe})
    `CHK("reset region", 3'h0, {region, wdir})
    go(8'h00, 2'h0, 1'b1, 1);
    repeat (4) @(posedge hclk);
    `CHK("strap high ignores go", 1'b1, attn)
    ahb(1'b0, ALP_STAT_OFS, 32'h0);
    `CHK("strap high mode", 1'b0, rd[ALP_ST_MODE_BIT])
    `CHK("okay response", 1'b0, hresp)
    print_verdict();
  end
endmodule // tb_active_mode_local_bus_port
